// [logic/rst_clk_pkg.sv]
// Constants and carriers for the clock-domain and reset sequencer.
// Assumes a single reference-rate clock; slower rates are enable pulses.
// How it works
// - Register-side logic runs on half-rate enable; the registers in rst_clk_seq update on every reference clock instead
// - Fabric logic runs at full reference rate
// - Each lane receive logic in own domain
// - Transmit logic clocked from reference clock
// - Serial clock divides half-rate by programmable value
// - Port power-down gates that port's clock
// - Reset release sequenced automatically, no software
// - Four reset symbols with no SYM_OTHER between trigger self-reset
// - Either reset source runs full reset sequence
// - After release, boot configuration from EEPROM
// - Hard reset input active low, asynchronous
// - Per-domain synchroniser releases hard reset
// - Reset request stays inactive (high) under hard reset
// - Reset exit within 1 ms of release
// - Self-reset enable defaults to enabled
// - Reset request held for whole self-reset
// - Disabled self-reset raises interrupt if enabled
// - Disabled: request held until status cleared
// - Interrupt output quiet while in reset
package rst_clk_pkg;

  // ==========================================================================
  // Register map (byte addresses, 32-bit words)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_DIVIDER  = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_REQ_CLR  = 8'h0C;

  // CTRL fields
  localparam int CTRL_SELF_RST_BIT  = 0;
  localparam int CTRL_IRQ_EN_BIT    = 1;
  localparam int CTRL_PWDN_LSB      = 8;

  localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0001;
  localparam logic [15:0] SCL_DIV_DEFAULT  = 16'h030E;  // 782

  // ==========================================================================
  // Timing
  localparam int CLOCK_MHZ         = 250;
  localparam int SELF_RST_MIN_REF  = 8;
  localparam int SELF_RST_CYCLES   = SELF_RST_MIN_REF * 2;
  localparam int EXIT_TIME_US      = 1000;
  localparam int EXIT_MAX_CYCLES   = EXIT_TIME_US * CLOCK_MHZ;
  localparam int STAGE_CYCLES      = 4;
  localparam int RST_SYMBOLS       = 4;

  // ==========================================================================
  // Symbol kinds from a port
  typedef enum logic [1:0] {
    SYM_NONE   = 2'b00,
    SYM_STATUS = 2'b01,
    SYM_RESET  = 2'b10,
    SYM_OTHER  = 2'b11
  } sym_kind_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef enum logic [2:0] {
    SEQ_HOLD    = 3'b000,
    SEQ_FABRIC  = 3'b001,
    SEQ_REGS    = 3'b010,
    SEQ_LANES   = 3'b011,
    SEQ_BOOT    = 3'b100,
    SEQ_RUN     = 3'b101
  } seq_state_t;

endpackage

// [logic/rst_clk_seq.sv]
// Reset sequencer, clock enables and port gating for the switch.
// Assumes one reference clock at 250 MHz; half rate and serial clock are
// enables, lane domains run on their recovered lane clocks.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module rst_clk_seq #(
  parameter int NUM_PORTS       = 4,
  parameter int EXIT_MAX_CYCLES = rst_clk_pkg::EXIT_MAX_CYCLES
) (
  input  wire logic                        i_clock,           // Reference clock
  input  wire logic                        i_rst,             // Async reset, high
  input  wire logic                        i_hard_reset_in_n, // Hard reset pin, low
  input  wire rst_clk_pkg::reg_req_t       i_reg,             // Register request
  output logic [31:0]                      o_rdata,           // Read data
  input  wire rst_clk_pkg::sym_kind_t [NUM_PORTS-1:0] i_sym,  // Per-port symbols
  input  wire logic [NUM_PORTS-1:0]        i_lane_clock,      // Recovered lane clocks
  input  wire logic                        i_boot_done,       // EEPROM load finished
  output logic                             o_half_en,         // Half-rate enable
  output logic                             o_scl_en,          // Serial clock toggle
  output logic                             o_scl,             // Serial clock level
  output logic [NUM_PORTS-1:0]             o_port_clk_en,     // Port clock enables
  output logic [NUM_PORTS-1:0]             o_lane_rst,        // Lane domain resets
  output logic                             o_fabric_rst,      // Fabric reset
  output logic                             o_regs_rst,        // Register reset
  output logic                             o_boot_start,      // Boot start pulse
  output logic                             o_reset_request_out_n, // Reset request
  output logic                             o_irq              // Interrupt
);

  // ==========================================================================
  // Reset combination and synchroniser
  logic self_rst_q;
  logic arst;
  logic [1:0] sync_q;
  logic dom_rst;

  assign arst = i_rst | ~i_hard_reset_in_n | self_rst_q;

  always_ff @(posedge i_clock or posedge arst) begin
    if (arst) begin
      sync_q <= 2'b11;
    end else begin
      sync_q <= {sync_q[0], 1'b0};
    end
  end
  assign dom_rst = sync_q[1];

  // ==========================================================================
  // Release sequence
  rst_clk_pkg::seq_state_t state_q;
  logic [2:0] stage_cnt_q;
  logic       boot_q;

  always_ff @(posedge i_clock or posedge dom_rst) begin
    if (dom_rst) begin
      state_q     <= rst_clk_pkg::SEQ_HOLD;
      stage_cnt_q <= 3'h0;
    end else if (state_q != rst_clk_pkg::SEQ_RUN && state_q != rst_clk_pkg::SEQ_BOOT) begin
      if (stage_cnt_q == 3'(rst_clk_pkg::STAGE_CYCLES - 1)) begin
        stage_cnt_q <= 3'h0;
        state_q     <= rst_clk_pkg::seq_state_t'(state_q + 3'h1);
      end else begin
        stage_cnt_q <= stage_cnt_q + 3'h1;
      end
    end else if (state_q == rst_clk_pkg::SEQ_BOOT && i_boot_done && !boot_q) begin
      // A done level left from the previous load is ignored while the start pulse stands
      state_q <= rst_clk_pkg::SEQ_RUN;
    end
  end

  assign o_fabric_rst = (state_q == rst_clk_pkg::SEQ_HOLD);
  assign o_regs_rst   = (state_q == rst_clk_pkg::SEQ_HOLD) |
                        (state_q == rst_clk_pkg::SEQ_FABRIC);

  // Lane domains get their own two-stage release on their recovered clock
  logic lanes_hold;
  assign lanes_hold = (state_q < rst_clk_pkg::SEQ_LANES);
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_lane
    logic [1:0] lsync_q;
    always_ff @(posedge i_lane_clock[p] or posedge lanes_hold) begin
      if (lanes_hold) begin
        lsync_q <= 2'b11;
      end else begin
        lsync_q <= {lsync_q[0], 1'b0};
      end
    end
    assign o_lane_rst[p] = lsync_q[1];
  end

  // Boot pulse on entering the boot state
  always_ff @(posedge i_clock or posedge dom_rst) begin
    if (dom_rst) begin
      boot_q <= 1'b0;
    end else begin
      boot_q <= (state_q == rst_clk_pkg::SEQ_LANES) &&
                (stage_cnt_q == 3'(rst_clk_pkg::STAGE_CYCLES - 1));
    end
  end
  assign o_boot_start = boot_q;

  // ==========================================================================
  // Registers (reset only by the full device reset)
  logic [31:0] ctrl_q;
  logic [15:0] div_q;
  logic        req_clr;
  logic        self_en;
  logic        irq_en;

  always_ff @(posedge i_clock or posedge dom_rst) begin
    if (dom_rst) begin
      ctrl_q <= rst_clk_pkg::CTRL_RESET_VALUE;
      div_q  <= rst_clk_pkg::SCL_DIV_DEFAULT;
    end else if (i_reg.wr && i_reg.addr == rst_clk_pkg::ADDR_CTRL) begin
      ctrl_q <= i_reg.wdata;
    end else if (i_reg.wr && i_reg.addr == rst_clk_pkg::ADDR_DIVIDER) begin
      div_q  <= i_reg.wdata[15:0];
    end
  end
  assign req_clr = i_reg.wr && i_reg.addr == rst_clk_pkg::ADDR_REQ_CLR && i_reg.wdata[0];
  assign self_en = ctrl_q[rst_clk_pkg::CTRL_SELF_RST_BIT];
  assign irq_en  = ctrl_q[rst_clk_pkg::CTRL_IRQ_EN_BIT];

  // ==========================================================================
  // Port gating
  always_ff @(posedge i_clock or posedge dom_rst) begin
    if (dom_rst) begin
      o_port_clk_en <= '1;
    end else begin
      o_port_clk_en <= ~ctrl_q[rst_clk_pkg::CTRL_PWDN_LSB +: NUM_PORTS];
    end
  end

  // ==========================================================================
  // Half rate and serial clock divider
  logic        half_q;
  logic [15:0] div_cnt_q;
  logic        scl_q;

  always_ff @(posedge i_clock or posedge dom_rst) begin
    if (dom_rst) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end
  assign o_half_en = half_q;

  // Divider counts half-rate ticks; one full period per programmed count
  always_ff @(posedge i_clock or posedge dom_rst) begin
    if (dom_rst) begin
      div_cnt_q <= 16'h0000;
      scl_q     <= 1'b1;
    end else if (half_q) begin
      if (div_cnt_q >= (div_q >> 1) - 16'h0001) begin
        div_cnt_q <= 16'h0000;
        scl_q     <= ~scl_q;
      end else begin
        div_cnt_q <= div_cnt_q + 16'h0001;
      end
    end
  end
  assign o_scl_en = half_q && (div_cnt_q >= (div_q >> 1) - 16'h0001);
  assign o_scl    = scl_q;

  // ==========================================================================
  // Reset-symbol counters
  logic [NUM_PORTS-1:0] hit;
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_cnt
    logic [2:0] cnt_q;
    always_ff @(posedge i_clock or posedge dom_rst) begin
      if (dom_rst) begin
        cnt_q <= 3'h0;
      end else if (i_sym[p] == rst_clk_pkg::SYM_RESET) begin
        cnt_q <= (cnt_q == 3'(rst_clk_pkg::RST_SYMBOLS)) ? cnt_q : cnt_q + 3'h1;
      end else if (i_sym[p] == rst_clk_pkg::SYM_OTHER) begin
        cnt_q <= 3'h0;
      end
    end
    assign hit[p] = (i_sym[p] == rst_clk_pkg::SYM_RESET) &&
                    (cnt_q == 3'(rst_clk_pkg::RST_SYMBOLS - 1));

    chk_count_clear: assert property (@(posedge i_clock) disable iff (dom_rst)
      i_sym[p] == rst_clk_pkg::SYM_OTHER |=> cnt_q == 3'h0) else $error("count not cleared");
  end

  // ==========================================================================
  // Request latch and self-reset pulse
  logic       req_q;
  logic [4:0] srst_cnt_q;
  logic       srst_run_q;

  always_ff @(posedge i_clock or posedge dom_rst) begin
    if (dom_rst) begin
      req_q <= 1'b0;
    end else if (|hit && !self_en) begin
      req_q <= 1'b1;
    end else if (req_clr) begin
      req_q <= 1'b0;
    end
  end

  // Self-reset runs on a counter cleared only by i_rst and the hard reset pin, so it survives
  // the internal reset it causes.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      srst_run_q <= 1'b0;
      srst_cnt_q <= 5'h00;
    end else if (!i_hard_reset_in_n) begin
      srst_run_q <= 1'b0;
      srst_cnt_q <= 5'h00;
    end else if (srst_run_q) begin
      if (srst_cnt_q == 5'(rst_clk_pkg::SELF_RST_CYCLES - 1)) begin
        srst_run_q <= 1'b0;
      end else begin
        srst_cnt_q <= srst_cnt_q + 5'h01;
      end
    end else if (|hit && self_en && !dom_rst) begin
      srst_run_q <= 1'b1;
      srst_cnt_q <= 5'h00;
    end
  end
  assign self_rst_q = srst_run_q;

  assign o_reset_request_out_n = ~(req_q | srst_run_q);

  logic irq_q;
  always_ff @(posedge i_clock or posedge dom_rst) begin
    if (dom_rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= req_q && irq_en;
    end
  end
  // The flop clears at once on reset, so the pin needs no extra gate
  assign o_irq = irq_q;

  // ==========================================================================
  // Read data
  always_ff @(posedge i_clock or posedge dom_rst) begin
    if (dom_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_reg.rd) begin
      unique case (i_reg.addr)
        rst_clk_pkg::ADDR_CTRL:    o_rdata <= ctrl_q;
        rst_clk_pkg::ADDR_DIVIDER: o_rdata <= {16'h0000, div_q};
        rst_clk_pkg::ADDR_STATUS:  o_rdata <= {27'h000_0000, state_q, srst_run_q, req_q};
        default:                   o_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  logic [17:0] exit_cnt_q;
  always_ff @(posedge i_clock or posedge arst) begin
    if (arst) begin
      exit_cnt_q <= 18'h0;
    end else if (o_regs_rst && exit_cnt_q != '1) begin
      exit_cnt_q <= exit_cnt_q + 18'h1;
    end
  end

  chk_exit_bound: assert property (@(posedge i_clock) disable iff (i_rst)
    exit_cnt_q < 18'(EXIT_MAX_CYCLES)) else $error("reset exit too slow");
  chk_req_hard: assert property (@(posedge i_clock)
    !i_hard_reset_in_n |=> o_reset_request_out_n) else $error("request under hard reset");
  chk_self_len: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(srst_run_q) |-> srst_run_q [*8]) else $error("self reset too short");
  chk_irq_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    dom_rst |-> !o_irq) else $error("irq during reset");
  chk_seq_order: assert property (@(posedge i_clock) disable iff (dom_rst)
    $fell(o_fabric_rst) |-> o_regs_rst) else $error("release order");
  chk_boot_after: assert property (@(posedge i_clock) disable iff (dom_rst)
    o_boot_start |-> !o_regs_rst) else $error("boot before release");
  chk_gate_pwdn: assert property (@(posedge i_clock) disable iff (dom_rst)
    ctrl_q[rst_clk_pkg::CTRL_PWDN_LSB] |=> !o_port_clk_en[0]) else $error("gate");
  chk_req_held: assert property (@(posedge i_clock) disable iff (dom_rst)
    req_q && !req_clr |=> req_q) else $error("request dropped");
  chk_irq_pending: assert property (@(posedge i_clock) disable iff (dom_rst)
    req_q && irq_en |=> o_irq) else $error("irq not raised");
  chk_half_toggle: assert property (@(posedge i_clock) disable iff (dom_rst)
    1'b1 |=> o_half_en != $past(o_half_en)) else $error("half rate stalled");
  chk_scl_step: assert property (@(posedge i_clock) disable iff (dom_rst)
    o_scl_en |=> o_scl != $past(o_scl)) else $error("serial clock missed step");
  // Self reset pulls the internal reset itself, so only the outer sources disable this
  chk_self_start: assert property (@(posedge i_clock)
    disable iff (i_rst || !i_hard_reset_in_n)
    |hit && self_en && !srst_run_q |=> srst_run_q) else $error("self reset not started");

  cov_self: cover property (@(posedge i_clock) $rose(srst_run_q));
  cov_req: cover property (@(posedge i_clock) $rose(req_q));
  cov_boot: cover property (@(posedge i_clock) o_boot_start);
  cov_hard: cover property (@(posedge i_clock) $fell(i_hard_reset_in_n));
  cov_req_clear: cover property (@(posedge i_clock) req_q && req_clr);

endmodule

// [testbench/link_peer_model.sv]
// Link peers and configuration loader facing the reset sequencer.
// Assumes the bench calls send_sym once for each symbol it wants sent.
`timescale 1ns/1ns
module link_peer_model #(
  parameter int NUM_PORTS   = 4,
  parameter int BOOT_CYCLES = 20
) (
  input  wire logic                              i_clock,      // Reference clock
  input  wire logic                              i_boot_start, // Boot start pulse
  output rst_clk_pkg::sym_kind_t [NUM_PORTS-1:0] o_sym,        // Symbols per port
  output logic                                   o_boot_done   // Load finished
);
  int boot_cnt;

  initial begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      o_sym[i] = rst_clk_pkg::SYM_NONE;
    end
    o_boot_done = 1'b0;
    boot_cnt = 0;
  end

  // ==========================================================================
  // Symbol stream: one symbol for one cycle, then idle, so nothing repeats
  task automatic send_sym(input int port, input rst_clk_pkg::sym_kind_t kind);
    @(posedge i_clock);
    o_sym[port] <= kind;
    @(posedge i_clock);
    o_sym[port] <= rst_clk_pkg::SYM_NONE;
  endtask

  // ==========================================================================
  // Loader: busy for a fixed time after each start, never instant
  always @(posedge i_clock) begin
    if (i_boot_start === 1'b1) begin
      o_boot_done <= 1'b0;
      boot_cnt <= BOOT_CYCLES;
    end else if (boot_cnt > 1) begin
      boot_cnt <= boot_cnt - 1;
    end else if (boot_cnt == 1) begin
      o_boot_done <= 1'b1;
      boot_cnt <= 0;
    end
  end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the reset sequencer and its clock enables.
// Assumes one 250 MHz reference clock; lane clocks are free running.
`timescale 1ns/1ns
module tb_top;
  localparam int NP = 4;
  logic                            i_clock = 1'b0;
  logic                            i_rst = 1'b1;
  logic                            hard_n = 1'b1;
  logic                            lane_ck = 1'b0;
  rst_clk_pkg::reg_req_t           reg_req = '0;
  rst_clk_pkg::sym_kind_t [NP-1:0] sym;
  logic [31:0]                     rdata;
  logic                            boot_done, half_en, scl_en, scl, fab_rst, regs_rst;
  logic                            boot_start, req_n, irq, prev;
  logic [NP-1:0]                   clk_en, lane_rst;
  int                              err_total = 0;
  int                              cmp_count = 0;
  int                              n0, n1;

  rst_clk_seq #(.NUM_PORTS(NP), .EXIT_MAX_CYCLES(64)) i_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_hard_reset_in_n(hard_n), .i_reg(reg_req),
    .o_rdata(rdata), .i_sym(sym), .i_lane_clock({NP{lane_ck}}), .i_boot_done(boot_done),
    .o_half_en(half_en), .o_scl_en(scl_en), .o_scl(scl), .o_port_clk_en(clk_en),
    .o_lane_rst(lane_rst), .o_fabric_rst(fab_rst), .o_regs_rst(regs_rst),
    .o_boot_start(boot_start), .o_reset_request_out_n(req_n), .o_irq(irq));

  link_peer_model #(.NUM_PORTS(NP), .BOOT_CYCLES(20)) i_peer (
    .i_clock(i_clock), .i_boot_start(boot_start), .o_sym(sym), .o_boot_done(boot_done));

  initial forever #2 i_clock = ~i_clock;
  initial forever #3 lane_ck = ~lane_ck;

  // ==========================================================================
  // Common tasks
  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clock);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clock);
    reg_req.rd <= 1'b0;
    #1 chk(name, exp, rdata);
  endtask

  // Each reset symbol is followed by a filler symbol
  task automatic resets(input int p, input int n, input rst_clk_pkg::sym_kind_t gap);
    repeat (n) begin
      i_peer.send_sym(p, rst_clk_pkg::SYM_RESET);
      i_peer.send_sym(p, gap);
    end
  endtask

  task automatic count_scl(output int n);
    logic last;
    logic en;
    int   bad;
    n = 0;
    bad = 0;
    tick(1);
    last = scl;
    repeat (200) begin
      en = scl_en;
      tick(1);
      if (scl !== last) begin
        n++;
        if (en !== 1'b1) bad++;
      end
      last = scl;
    end
    chk("scl_en_lead", 0, bad);
  endtask

  // Waits for boot start, then for the loader, so resets stay spaced
  task automatic wait_boot();
    int f, r, n;
    f = -1;
    r = -1;
    for (n = 0; n < 400; n++) begin
      tick(1);
      if (f < 0 && fab_rst === 1'b0) f = n;
      if (r < 0 && regs_rst === 1'b0) r = n;
      if (boot_start === 1'b1) break;
    end
    if (n >= 400) begin
      err_total++;
      summarize();
    end
    chk("fabric_before_regs", 1, f >= 0 && f <= r);
    chk("regs_before_boot", 1, r >= 0);
    chk("lane_rst", 0, lane_rst);
    chk("exit_time", 1, n < 64);
    tick(1);
    for (n = 0; n < 100 && boot_done !== 1'b1; n++) tick(1);
    if (boot_done !== 1'b1) begin
      chk("boot_done", 1, boot_done);
      summarize();
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic sc_regs_clocks();
    rdchk("ctrl_reset", rst_clk_pkg::ADDR_CTRL, rst_clk_pkg::CTRL_RESET_VALUE);
    rdchk("div_reset", rst_clk_pkg::ADDR_DIVIDER, {16'h0000, rst_clk_pkg::SCL_DIV_DEFAULT});
    rdchk("unmapped", 8'h10, 32'h0000_0000);
    tick(1);
    prev = half_en;
    tick(1);
    chk("half_en", !prev, half_en);
    count_scl(n0);
    chk("scl_default_slow", 0, n0);
    wr(rst_clk_pkg::ADDR_DIVIDER, 32'h0000_0004);
    count_scl(n1);
    chk("scl_small_div", 1, n1 >= 49 && n1 <= 51);
  endtask

  task automatic sc_request_held();
    wr(rst_clk_pkg::ADDR_CTRL, 32'h0000_0002);
    resets(1, 4, rst_clk_pkg::SYM_STATUS);
    tick(2);
    chk("req_n_latched", 0, req_n);
    chk("irq_raised", 1, irq);
    rdchk("status_req", rst_clk_pkg::ADDR_STATUS, {27'h000_0000, rst_clk_pkg::SEQ_RUN, 2'h1});
    chk("no_self_reset", 0, fab_rst);
    wr(rst_clk_pkg::ADDR_REQ_CLR, 32'h0000_0001);
    tick(2);
    chk("req_n_cleared", 1, req_n);
    wr(rst_clk_pkg::ADDR_CTRL, 32'h0000_0000);
    resets(2, 3, rst_clk_pkg::SYM_NONE);
    i_peer.send_sym(2, rst_clk_pkg::SYM_OTHER);
    resets(2, 1, rst_clk_pkg::SYM_NONE);
    tick(2);
    chk("count_cleared", 1, req_n);
    resets(2, 3, rst_clk_pkg::SYM_NONE);
    tick(2);
    chk("req_n_again", 0, req_n);
    chk("irq_masked", 0, irq);
  endtask

  task automatic sc_hard_reset();
    @(posedge i_clock);
    hard_n <= 1'b0;
    tick(2);
    chk("req_n_hard", 1, req_n);
    chk("irq_hard", 0, irq);
    chk("all_rst", 4'h7, {fab_rst, regs_rst, lane_rst[0]});
    tick(20);
    hard_n <= 1'b1;
    tick(1);
    chk("sync_release", 1, fab_rst);
    wait_boot();
    chk("req_n_after", 1, req_n);
  endtask

  task automatic sc_self_reset();
    int low;
    wr(rst_clk_pkg::ADDR_CTRL, 32'h0000_0401);
    wr(rst_clk_pkg::ADDR_DIVIDER, 32'h0000_0004);
    tick(2);
    chk("port_gate", 4'b1011, clk_en);
    resets(3, 4, rst_clk_pkg::SYM_NONE);
    low = 0;
    for (int n = 0; n < 100; n++) begin
      tick(1);
      if (req_n === 1'b0) begin
        low++;
        if (low == 1) chk("fabric_in_self", 1, fab_rst);
      end else if (low > 0) break;
    end
    chk("req_low_len", 1, low >= 8);
    chk("req_released", 1, req_n);
    wait_boot();
    rdchk("ctrl_restored", rst_clk_pkg::ADDR_CTRL, rst_clk_pkg::CTRL_RESET_VALUE);
    chk("gate_restored", 4'hF, clk_en);
    rdchk("div_back", rst_clk_pkg::ADDR_DIVIDER, {16'h0000, rst_clk_pkg::SCL_DIV_DEFAULT});
    wr(rst_clk_pkg::ADDR_DIVIDER, 32'h0000_0006);
    rdchk("div_reinit", rst_clk_pkg::ADDR_DIVIDER, 32'h0000_0006);
  endtask

  initial begin
    tick(2);
    chk("req_n_in_rst", 1, req_n);
    chk("irq_in_rst", 0, irq);
    tick(10);
    i_rst <= 1'b0;
    wait_boot();
    sc_regs_clocks();
    sc_request_held();
    sc_hard_reset();
    sc_self_reset();
    summarize();
  end
endmodule
